// *** src/scd_pkg.sv ***
// package for the serial command and configuration decoder
// assumes a single 50 MHz clock domain
package scd_pkg;
    localparam int SCD_CMD_BITS  = 8;
    localparam int SCD_DATA_BITS = 24;
    localparam logic [2:0] SCD_SEL_RESULT  = 3'h0;
    localparam logic [2:0] SCD_SEL_CONFIG  = 3'h1;
    localparam logic [2:0] SCD_SEL_GAIN    = 3'h2;
    localparam logic [2:0] SCD_SEL_DAC     = 3'h3;
    localparam logic [2:0] SCD_SEL_SIGRAT  = 3'h4;
    localparam logic [2:0] SCD_SEL_REFNR   = 3'h5;
    localparam logic [2:0] SCD_SEL_SIGNR   = 3'h6;
    localparam logic [2:0] SCD_SEL_UNUSED  = 3'h7;
    // configuration field positions
    localparam int SCD_CFG_SIGN     = 23;
    localparam int SCD_CFG_MAG_HI   = 22;
    localparam int SCD_CFG_MAG_LO   = 20;
    localparam int SCD_CFG_EXC      = 19;
    localparam int SCD_CFG_RATE_HI  = 18;
    localparam int SCD_CFG_RATE_LO  = 17;
    localparam int SCD_CFG_GAIN_HI  = 15;
    localparam int SCD_CFG_GAIN_LO  = 14;
    localparam int SCD_CFG_POL      = 13;
    localparam int SCD_CFG_SLEEP    = 11;
    localparam int SCD_CFG_CALGO    = 10;
    localparam int SCD_CFG_KIND_HI  = 7;
    localparam int SCD_CFG_KIND_LO  = 4;
    localparam int SCD_CFG_FCLR     = 0;
    // writable configuration bits: excludes dac mirror and reserved bits
    localparam logic [23:0] SCD_CFG_WMASK = 24'h0EECF1;
    // reset values
    localparam logic [23:0] SCD_CFG_RESET  = 24'h000000;
    localparam logic [23:0] SCD_GAIN_RESET = 24'h800000;
    localparam logic [23:0] SCD_ZERO_RESET = 24'h000000;
    // calibration kinds
    localparam logic [3:0] SCD_CAL_NONE   = 4'h0;
    localparam logic [3:0] SCD_CAL_REFNR  = 4'h8;
    localparam logic [3:0] SCD_CAL_SIGNR  = 4'h4;
    localparam logic [3:0] SCD_CAL_SIGRAT = 4'h2;
    localparam logic [3:0] SCD_CAL_GAIN   = 4'h1;
    localparam logic [3:0] SCD_CAL_BOTHNR = 4'hC;
    // excitation divide ratios of the master clock
    localparam int SCD_DIV_RATE1 = 8192;
    localparam int SCD_DIV_RATE2 = 16384;
    localparam int SCD_DIV_RATE3 = 4096;
    // cycles from command decode to read word presented
    localparam int SCD_READ_PREP_CYC = 4;
    // shortened default calibration time in master clock cycles
    localparam int SCD_CAL_CYC = 573440;
    localparam int SCD_CAL_RAT_CYC = 2211840;
    typedef enum logic [1:0] {
        SCD_ST_CMD   = 2'b00,
        SCD_ST_PREP  = 2'b01,
        SCD_ST_DATA  = 2'b10,
        SCD_ST_CAL   = 2'b11
    } scd_state_t;
endpackage

// *** src/scd_sync.sv ***
// two flip-flop synchroniser for one pin level
// assumes the pin is asynchronous to clock
`timescale 1ns/1ns
`default_nettype none
module scd_sync (
    input  wire logic clock,
    input  wire logic rst,
    input  wire logic pin_in,
    output var  logic level_out
);
    logic stage1;
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            stage1    <= 1'b0;
            level_out <= 1'b0;
        end else begin
            stage1    <= pin_in;
            level_out <= stage1;
        end
    end
endmodule
`default_nettype wire

// *** src/scd_decoder.sv ***
// serial command interpreter and configuration register
// assumes host drives port pins asynchronously; rst is the reset pin
// Behaviour
// - select field picks target register
// - direction bit: zero write, one read
// - after reset, first eight bits are command
// - valid command starts 24-bit data phase
// - write data may follow command immediately
// - read waits for result_ready_n low
// - chip select high ends result read early
// - configuration write is decoded and executed
// - offset sign and magnitude fields
// - offset dac bits mirror dac register
// - excitation source chooses internal or external drive
// - excitation rate chooses dc or divided clock
// - calibrate_go starts selected calibration
// - calibration_kind codes select calibration
// - filter_clear resets digital filter
// - reset clears config, inits calibration, command mode
// - calibrate_go set reruns calibration per write
// - result_ready_n high during calibration, then low
`timescale 1ns/1ns
`default_nettype none
module scd_decoder
    import scd_pkg::*;
#(
    parameter int CAL_CYC     = scd_pkg::SCD_CAL_CYC,
    parameter int CAL_RAT_CYC = scd_pkg::SCD_CAL_RAT_CYC,
    parameter int DIV_RATE1   = scd_pkg::SCD_DIV_RATE1,
    parameter int DIV_RATE2   = scd_pkg::SCD_DIV_RATE2,
    parameter int DIV_RATE3   = scd_pkg::SCD_DIV_RATE3
) (
    input  wire logic        clock,
    input  wire logic        rst,
    input  wire logic        port_select_n,
    input  wire logic        shift_clock,
    input  wire logic        serial_in,
    output var  logic        serial_out,
    output var  logic        serial_out_en,
    output var  logic        result_ready_n,
    input  wire logic        bridge_drive_a_in,
    output var  logic        bridge_drive_a_out,
    output var  logic        bridge_drive_a_en,
    output var  logic        bridge_drive_b,
    input  wire logic [23:0] result_word,
    input  wire logic        result_valid,
    output var  logic [3:0]  pga_gain,
    output var  logic        unipolar,
    output var  logic        sleep_mode,
    output var  logic        filter_clear,
    output var  logic        demod_phase,
    output var  logic [3:0]  cal_active_kind,
    output var  logic [2:0]  offset_magnitude,
    output var  logic        offset_sign
);
    import scd_pkg::*;

    // counters are 22 and 14 bits wide
    if (CAL_CYC < 1 || CAL_CYC > 4194304 || CAL_RAT_CYC < 1 ||
        CAL_RAT_CYC > 4194304 || DIV_RATE1 < 2 || DIV_RATE1 > 32768 ||
        DIV_RATE2 < 2 || DIV_RATE2 > 32768 || DIV_RATE3 < 2 ||
        DIV_RATE3 > 32768) begin : g_bad_param
        $error("scd_decoder: bad parameter");
    end

    // pin synchronisers
    logic cs_n_s;
    logic sclk_s;
    logic sdi_s;
    logic bxa_s;
    scd_sync u_sync_cs (.clock(clock), .rst(rst), .pin_in(port_select_n),
                        .level_out(cs_n_s));
    scd_sync u_sync_sck (.clock(clock), .rst(rst), .pin_in(shift_clock),
                         .level_out(sclk_s));
    scd_sync u_sync_sdi (.clock(clock), .rst(rst), .pin_in(serial_in),
                         .level_out(sdi_s));
    scd_sync u_sync_bxa (.clock(clock), .rst(rst),
                         .pin_in(bridge_drive_a_in), .level_out(bxa_s));

    logic sclk_d;
    wire  sclk_fall = ~sclk_s & sclk_d & ~cs_n_s;

    scd_state_t  state;
    logic [7:0]  serial_command_word;
    logic [4:0]  bit_count;
    logic [23:0] shift_reg;
    logic [23:0] operating_setup_word;
    logic [23:0] gain_reg;
    logic [23:0] dac_reg;
    logic [23:0] sig_rat_reg;
    logic [23:0] ref_nr_reg;
    logic [23:0] sig_nr_reg;
    logic [21:0] wait_count;
    logic        result_fresh;

    // command field decode
    wire [2:0] cmd_sel   = serial_command_word[6:4];
    wire       cmd_read  = serial_command_word[3];
    wire       cmd_ok    = serial_command_word[7] &
                           (serial_command_word[2:0] == 3'h0);
    wire       sel_result = (cmd_sel == SCD_SEL_RESULT);

    wire [7:0] next_cmd  = {serial_command_word[6:0], sdi_s};
    wire       cmd_done  = (state == SCD_ST_CMD) && sclk_fall &&
                           (bit_count == 5'(SCD_CMD_BITS - 1));
    wire       data_last = (state == SCD_ST_DATA) && sclk_fall &&
                           (bit_count == 5'(SCD_DATA_BITS - 1));
    wire       wr_done   = data_last && !cmd_read && cmd_ok;

    // incoming write word with dac mirror kept and reserved bits cleared
    wire [23:0] wdata     = {shift_reg[22:0], sdi_s};
    wire [23:0] cfg_write = (wdata & SCD_CFG_WMASK) |
                            {dac_reg[3:0], 20'h00000};
    wire        cal_go_new = cfg_write[SCD_CFG_CALGO];
    wire        cal_go_cur = operating_setup_word[SCD_CFG_CALGO];
    // a completed write with the go bit set runs calibration
    wire        cal_start = wr_done &&
                    ((cmd_sel == SCD_SEL_CONFIG) ? cal_go_new
                                                 : cal_go_cur);
    wire [3:0]  cal_kind_sel = (cmd_sel == SCD_SEL_CONFIG) ?
                    cfg_write[SCD_CFG_KIND_HI:SCD_CFG_KIND_LO] :
                    operating_setup_word[SCD_CFG_KIND_HI:SCD_CFG_KIND_LO];
    wire        cal_is_rat = (cal_active_kind == SCD_CAL_SIGRAT);
    wire [21:0] cal_len = cal_is_rat ? 22'(CAL_RAT_CYC - 1)
                                     : 22'(CAL_CYC - 1);

    // register read selection
    logic [23:0] read_word;
    always_comb begin
        case (cmd_sel)
            SCD_SEL_RESULT: read_word = result_word;
            SCD_SEL_CONFIG: read_word = operating_setup_word;
            SCD_SEL_GAIN:   read_word = gain_reg;
            SCD_SEL_DAC:    read_word = dac_reg;
            SCD_SEL_SIGRAT: read_word = sig_rat_reg;
            SCD_SEL_REFNR:  read_word = ref_nr_reg;
            SCD_SEL_SIGNR:  read_word = sig_nr_reg;
            default:        read_word = 24'h000000;
        endcase
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            sclk_d <= 1'b0;
        end else begin
            sclk_d <= sclk_s;
        end
    end

    // interpreter state machine
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            state               <= SCD_ST_CMD;
            serial_command_word <= 8'h00;
            bit_count           <= 5'h00;
            shift_reg           <= 24'h000000;
            wait_count          <= 22'h000000;
            result_ready_n      <= 1'b1;
            cal_active_kind     <= SCD_CAL_NONE;
        end else begin
            case (state)
                SCD_ST_CMD: begin
                    if (sclk_fall) begin
                        serial_command_word <= next_cmd;
                        bit_count <= bit_count + 5'h01;
                    end
                    if (cmd_done) begin
                        bit_count <= 5'h00;
                        if (next_cmd[3]) begin
                            state      <= SCD_ST_PREP;
                            result_ready_n <= 1'b1;
                            wait_count <= 22'(SCD_READ_PREP_CYC - 1);
                        end else begin
                            state <= SCD_ST_DATA;
                        end
                    end
                end
                SCD_ST_PREP: begin
                    if (wait_count != 22'h000000) begin
                        wait_count <= wait_count - 22'h000001;
                    end else if (!sel_result || result_fresh) begin
                        shift_reg      <= read_word;
                        result_ready_n <= 1'b0;
                        state          <= SCD_ST_DATA;
                    end
                end
                SCD_ST_DATA: begin
                    if (sclk_fall) begin
                        bit_count <= bit_count + 5'h01;
                        if (!cmd_read) begin
                            shift_reg <= {shift_reg[22:0], sdi_s};
                        end else begin
                            shift_reg <= {shift_reg[22:0], 1'b0};
                        end
                    end
                    if (cmd_read && sel_result && cs_n_s) begin
                        state          <= SCD_ST_CMD;
                        bit_count      <= 5'h00;
                        result_ready_n <= 1'b1;
                    end else if (data_last) begin
                        bit_count      <= 5'h00;
                        result_ready_n <= 1'b1;
                        if (cal_start) begin
                            state           <= SCD_ST_CAL;
                            cal_active_kind <= cal_kind_sel;
                            wait_count      <= cal_kind_sel ==
                                SCD_CAL_SIGRAT ? 22'(CAL_RAT_CYC - 1)
                                               : 22'(CAL_CYC - 1);
                        end else begin
                            state <= SCD_ST_CMD;
                        end
                    end
                end
                SCD_ST_CAL: begin
                    result_ready_n <= 1'b1;
                    if (wait_count > cal_len) begin
                        wait_count <= cal_len;
                    end else if (wait_count != 22'h000000) begin
                        wait_count <= wait_count - 22'h000001;
                    end else begin
                        result_ready_n  <= 1'b0;
                        cal_active_kind <= SCD_CAL_NONE;
                        state           <= SCD_ST_CMD;
                    end
                end
                default: state <= SCD_ST_CMD;
            endcase
        end
    end

    // register writes; calibration results come from outside this block
    wire        wr_now = wr_done;
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            operating_setup_word <= SCD_CFG_RESET;
            gain_reg    <= SCD_GAIN_RESET;
            dac_reg     <= SCD_ZERO_RESET;
            sig_rat_reg <= SCD_ZERO_RESET;
            ref_nr_reg  <= SCD_ZERO_RESET;
            sig_nr_reg  <= SCD_ZERO_RESET;
        end else if (wr_now) begin
            case (cmd_sel)
                SCD_SEL_CONFIG:
                    operating_setup_word <= cfg_write;
                SCD_SEL_GAIN:   gain_reg    <= wdata;
                SCD_SEL_DAC: begin
                    dac_reg <= wdata;
                    operating_setup_word[23:20] <= wdata[3:0];
                end
                SCD_SEL_SIGRAT: sig_rat_reg <= wdata;
                SCD_SEL_REFNR:  ref_nr_reg  <= wdata;
                SCD_SEL_SIGNR:  sig_nr_reg  <= wdata;
                default: ;
            endcase
        end
    end

    // result freshness: set by result_valid, cleared when a result read loads the read word
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            result_fresh <= 1'b0;
        end else if (result_valid) begin
            result_fresh <= 1'b1;
        end else if (state == SCD_ST_PREP && sel_result &&
                     wait_count == 22'h000000) begin
            result_fresh <= 1'b0;
        end
    end

    // serial output, driven while selected in a read data phase
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            serial_out    <= 1'b0;
            serial_out_en <= 1'b0;
        end else begin
            serial_out    <= shift_reg[23];
            serial_out_en <= (state == SCD_ST_DATA) && cmd_read && !cs_n_s;
        end
    end

    // configuration decode
    wire [1:0] rate = operating_setup_word[SCD_CFG_RATE_HI:SCD_CFG_RATE_LO];
    wire       ext_exc = operating_setup_word[SCD_CFG_EXC];
    logic [13:0] exc_div;
    wire [13:0] exc_half = (rate == 2'h1) ? 14'(DIV_RATE1 / 2 - 1) :
                           (rate == 2'h2) ? 14'(DIV_RATE2 / 2 - 1) :
                                            14'(DIV_RATE3 / 2 - 1);
    logic exc_phase;
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            exc_div   <= 14'h0000;
            exc_phase <= 1'b0;
        end else if (rate == 2'h0) begin
            exc_div   <= 14'h0000;
            exc_phase <= 1'b0;
        end else if (exc_div >= exc_half) begin
            exc_div   <= 14'h0000;
            exc_phase <= ~exc_phase;
        end else begin
            exc_div <= exc_div + 14'h0001;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            bridge_drive_a_out <= 1'b0;
            bridge_drive_a_en  <= 1'b1;
            bridge_drive_b     <= 1'b1;
            demod_phase        <= 1'b0;
            pga_gain           <= 4'h1;
            unipolar           <= 1'b0;
            sleep_mode         <= 1'b0;
            filter_clear       <= 1'b0;
            offset_magnitude   <= 3'h0;
            offset_sign        <= 1'b0;
        end else begin
            if (ext_exc) begin
                bridge_drive_a_out <= 1'b0;
                bridge_drive_a_en  <= 1'b0;
                bridge_drive_b     <= ~bxa_s;
                demod_phase        <= bxa_s;
            end else begin
                bridge_drive_a_en  <= 1'b1;
                bridge_drive_a_out <= (rate == 2'h0) ? 1'b0 : exc_phase;
                bridge_drive_b     <= (rate == 2'h0) ? 1'b1 : ~exc_phase;
                demod_phase        <= exc_phase;
            end
            case (operating_setup_word[SCD_CFG_GAIN_HI:SCD_CFG_GAIN_LO])
                2'h0:    pga_gain <= 4'h1;
                2'h2:    pga_gain <= 4'h2;
                2'h1:    pga_gain <= 4'h4;
                default: pga_gain <= 4'h8;
            endcase
            unipolar     <= operating_setup_word[SCD_CFG_POL];
            sleep_mode   <= operating_setup_word[SCD_CFG_SLEEP];
            filter_clear <= operating_setup_word[SCD_CFG_FCLR];
            offset_sign  <= operating_setup_word[SCD_CFG_SIGN];
            offset_magnitude <=
                operating_setup_word[SCD_CFG_MAG_HI:SCD_CFG_MAG_LO];
        end
    end
endmodule
`default_nettype wire

// *** testbench/scd_decoder_sva.sv ***
// port-level checker for the serial command decoder
// assumes one clock domain and the asynchronous active high reset
`timescale 1ns/1ns
`default_nettype none
module scd_decoder_sva (
    input wire logic       clock,
    input wire logic       rst,
    input wire logic       port_select_n,
    input wire logic       serial_out_en,
    input wire logic       result_ready_n,
    input wire logic [3:0] pga_gain,
    input wire logic       unipolar,
    input wire logic       sleep_mode,
    input wire logic       filter_clear,
    input wire logic [3:0] cal_active_kind,
    input wire logic [2:0] offset_magnitude,
    input wire logic       offset_sign
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    sequence cal_done_s;
        (cal_active_kind != 4'h0) ##1 (cal_active_kind == 4'h0);
    endsequence
    AST_RESET_OUT: assert property (disable iff (1'b0)
        rst |-> result_ready_n && !serial_out_en && cal_active_kind == 4'h0)
        else $error("outputs not at reset level");
    AST_RESET_CFG: assert property (disable iff (1'b0)
        rst |-> pga_gain == 4'h1 && !unipolar && !sleep_mode && !filter_clear
        && {offset_sign, offset_magnitude} == 4'h0)
        else $error("configuration outputs not cleared by reset");
    AST_GAIN_CODE: assert property (
        pga_gain inside {4'h1, 4'h2, 4'h4, 4'h8})
        else $error("gain outside 1,2,4,8");
    AST_CAL_KIND: assert property (
        cal_active_kind inside {4'h0, 4'h8, 4'h4, 4'h2, 4'h1, 4'hC})
        else $error("unknown calibration kind active");
    AST_CAL_BUSY: assert property (
        cal_active_kind != 4'h0 |-> result_ready_n)
        else $error("ready low during calibration");
    AST_CAL_DONE: assert property (
        cal_done_s |-> ##[0:3] !result_ready_n)
        else $error("ready did not fall after calibration");
    AST_CFG_SOURCE: assert property (
        $changed({pga_gain, unipolar, sleep_mode, filter_clear})
        |-> !$past(port_select_n, 4))
        else $error("configuration changed without a port access");
    AST_DESELECT: assert property (
        port_select_n [*4] |-> !serial_out_en)
        else $error("serial output driven while deselected");
endmodule
bind scd_decoder scd_decoder_sva u_sva (.clock(clock), .rst(rst),
    .port_select_n(port_select_n), .serial_out_en(serial_out_en),
    .result_ready_n(result_ready_n), .pga_gain(pga_gain),
    .unipolar(unipolar), .sleep_mode(sleep_mode),
    .filter_clear(filter_clear), .cal_active_kind(cal_active_kind),
    .offset_magnitude(offset_magnitude), .offset_sign(offset_sign));
`default_nettype wire

// *** testbench/scd_host.sv ***
// host controller model driving the serial port pins
// assumes bits are taken on the falling shift clock edge, msb first
`timescale 1ns/1ns
`default_nettype none
module scd_host (
    input  wire logic clock,
    input  wire logic serial_out,
    input  wire logic result_ready_n,
    output var  logic port_select_n,
    output var  logic shift_clock,
    output var  logic serial_in
);
    initial begin
        port_select_n = 1'b1;
        shift_clock   = 1'b1;
        serial_in     = 1'b0;
    end
    // each shift clock level held five master clocks
    task automatic bit_io(input logic b, output logic s);
        shift_clock = 1'b1;
        serial_in = b;
        repeat (5) @(negedge clock);
        s = serial_out;
        shift_clock = 1'b0;
        repeat (5) @(negedge clock);
    endtask
    task automatic xfer(input logic [7:0] cmd, input logic [23:0] wd,
                        input int n, output logic [23:0] rd);
        logic s;
        int   w;
        rd = 24'h0;
        repeat (4) @(negedge clock);
        port_select_n = 1'b0;
        for (int i = 7; i >= 0; i--) bit_io(cmd[i], s);
        if (cmd[3]) begin
            for (w = 0; w < 200 && result_ready_n !== 1'b0; w++)
                @(negedge clock);
        end
        for (int i = 23; i >= 24 - n; i--) begin
            bit_io(wd[i], s);
            rd[i] = s;
        end
        repeat (8) @(negedge clock);
        port_select_n = 1'b1;
        serial_in = ~serial_in;
    endtask
endmodule
`default_nettype wire

// *** testbench/serial_command_config_decoder_test.sv ***
// self-checking bench for the serial command decoder
// assumes the host model and the bound checker are compiled alongside
`timescale 1ns/1ns
`default_nettype none
module serial_command_config_decoder_test;
    import scd_pkg::*;
    logic        clock, rst, port_select_n, shift_clock, serial_in;
    logic        serial_out, serial_out_en, result_ready_n, prev;
    logic        a_in, a_out, a_en, bridge_b, result_valid, demod;
    logic        unipolar, sleep_mode, filter_clear, off_sign;
    logic [2:0]  off_mag;
    logic [3:0]  pga_gain, cal_kind;
    logic [23:0] result_word, rd;
    logic [3:0]  gexp [4] = '{4'h1, 4'h4, 4'h2, 4'h8};
    logic [3:0]  kinds [5] = '{4'h8, 4'h4, 4'h2, 4'h1, 4'hC};
    int          divs [4] = '{1, 16, 32, 8};
    int          err_count, n_compared, toggles, i;
    scd_decoder #(.CAL_CYC(20), .CAL_RAT_CYC(40), .DIV_RATE1(16),
                  .DIV_RATE2(32), .DIV_RATE3(8)) dut (
        .clock(clock), .rst(rst), .port_select_n(port_select_n),
        .shift_clock(shift_clock), .serial_in(serial_in),
        .serial_out(serial_out), .serial_out_en(serial_out_en),
        .result_ready_n(result_ready_n), .bridge_drive_a_in(a_in),
        .bridge_drive_a_out(a_out), .bridge_drive_a_en(a_en),
        .bridge_drive_b(bridge_b), .result_word(result_word),
        .result_valid(result_valid), .pga_gain(pga_gain),
        .unipolar(unipolar), .sleep_mode(sleep_mode),
        .filter_clear(filter_clear), .demod_phase(demod),
        .cal_active_kind(cal_kind), .offset_magnitude(off_mag),
        .offset_sign(off_sign));
    // a released data line shows the inverse of the last bit
    scd_host host (.clock(clock),
        .serial_out(serial_out_en ? serial_out : ~serial_out),
        .result_ready_n(result_ready_n), .port_select_n(port_select_n),
        .shift_clock(shift_clock), .serial_in(serial_in));
    task automatic check(input logic [23:0] seen, input logic [23:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_count++;
            $display("wrong value at %0t: %h not %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [2:0] sel, input logic [23:0] d);
        host.xfer({1'b1, sel, 4'h0}, d, 24, rd);
    endtask
    task automatic rdr(input logic [2:0] sel, input int n);
        host.xfer({1'b1, sel, 4'h8}, 24'h0, n, rd);
    endtask
    task automatic wait_ready;
        for (int w = 0; w < 100 && result_ready_n !== 1'b0; w++)
            @(negedge clock);
        check(24'(result_ready_n), 24'h0);
    endtask
    task automatic wrap_up;
        if (err_count == 0 && n_compared > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task automatic do_reset;
        rst = 1'b1;
        repeat (16) @(negedge clock);
        rst = 1'b0;
        repeat (4) @(negedge clock);
    endtask
    initial begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end
    initial begin
        repeat (60000) @(posedge clock);
        err_count++;
        wrap_up();
    end
    initial begin
        a_in = 1'b0;
        result_word = 24'h0;
        result_valid = 1'b0;
        err_count = 0;
        n_compared = 0;
        do_reset();
        rdr(SCD_SEL_GAIN, 24);
        check(rd, SCD_GAIN_RESET);
        for (i = 4; i < 7; i++) begin
            rdr(i[2:0], 24);
            check(rd, 24'h0);
        end
        rdr(SCD_SEL_CONFIG, 24);
        check(rd, SCD_CFG_RESET);
        for (i = 0; i < 4; i++) begin
            wr(SCD_SEL_CONFIG, {4'hF, 4'h0, i[1:0], i[0], 1'b0, i[1],
                                10'h0, i[0]});
            check(24'(pga_gain), 24'(gexp[i]));
            check(24'(unipolar), 24'(i[0]));
            check(24'(sleep_mode), 24'(i[1]));
            check(24'(filter_clear), 24'(i[0]));
            rdr(SCD_SEL_CONFIG, 24);
            check(24'(rd[23:20]), 24'h0);
        end
        wr(SCD_SEL_DAC, 24'h00000B);
        check(24'({off_sign, off_mag}), 24'hB);
        wr(SCD_SEL_UNUSED, 24'hFFFFFF);
        host.xfer(8'h10, 24'h000000, 24, rd);
        rdr(SCD_SEL_CONFIG, 24);
        check(rd, 24'hB0E801);
        wr(SCD_SEL_CONFIG, 24'h000000);
        check(24'({a_en, a_out, bridge_b}), 24'h5);
        for (i = 1; i < 4; i++) begin
            wr(SCD_SEL_CONFIG, 24'(i) << 17);
            toggles = 0;
            prev = bridge_b;
            repeat (640) begin
                @(negedge clock);
                if (bridge_b !== prev) toggles++;
                prev = bridge_b;
            end
            check(24'(toggles >= 1280 / divs[i] - 1 &&
                      toggles <= 1280 / divs[i] + 1), 24'h1);
        end
        wr(SCD_SEL_CONFIG, 24'h080000);
        a_in = 1'b1;
        repeat (6) @(negedge clock);
        check(24'({a_en, demod}), 24'h1);
        result_word = 24'hA5C3E1;
        result_valid = 1'b1;
        @(negedge clock);
        result_valid = 1'b0;
        rdr(SCD_SEL_RESULT, 12);
        check(24'(rd[23:12]), 24'hA5C);
        rdr(SCD_SEL_GAIN, 24);
        check(rd, SCD_GAIN_RESET);
        for (i = 0; i < 5; i++) begin
            wr(SCD_SEL_CONFIG, {13'h0, 1'b1, 2'h0, kinds[i], 4'h0});
            check(24'({result_ready_n, cal_kind}), 24'(kinds[i]) | 24'h10);
            wait_ready();
            wr(SCD_SEL_GAIN, 24'h800000);
            check(24'(cal_kind), 24'(kinds[i]));
            wait_ready();
        end
        wr(SCD_SEL_CONFIG, 24'h000000);
        check(24'(cal_kind), 24'h0);
        do_reset();
        rdr(SCD_SEL_CONFIG, 24);
        check(rd, SCD_CFG_RESET);
        wrap_up();
    end
endmodule
`default_nettype wire
